/* serial_port_pkg.sv */
/*
  Shared constants of the serial port: register addresses, bit positions,
  reset values, mode codes and divider counts.
  Assumes an 8-bit special-function bus and a CPU clock of 10 MHz.
*/
package serial_port_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] SERIAL_CTRL_ADDR = 8'h98;
  localparam logic [7:0] SERIAL_BUF_ADDR  = 8'h99;
  localparam logic [7:0] POWER_CTRL_ADDR  = 8'h87;
  localparam logic [7:0] REG_RESET        = 8'h00;

  // ==========================================================
  // Control register bit positions
  localparam int B_MODE_HI = 7;
  localparam int B_MODE_LO = 6;
  localparam int B_MPQ     = 5;
  localparam int B_REN     = 4;
  localparam int B_TX9     = 3;
  localparam int B_RX9     = 2;
  localparam int B_TXDONE  = 1;
  localparam int B_RXDONE  = 0;

  // Power control register bit positions
  localparam int B_BAUD_DOUBLE = 7;
  localparam int B_FRAME_VIEW  = 6;

  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    MODE_SHIFT  = 2'b00,
    MODE_UART8  = 2'b01,
    MODE_UART9F = 2'b10,
    MODE_UART9V = 2'b11
  } mode_t;

  // ==========================================================
  // Timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int SHIFT_DIV      = 6;
  localparam int SHIFT_HALF     = SHIFT_DIV / 2;
  localparam int OVERSAMPLE     = 16;
  localparam logic [3:0] SMP_A  = 4'h6;
  localparam logic [3:0] SMP_B  = 4'h7;
  localparam logic [3:0] SMP_C  = 4'h8;
  localparam logic [3:0] SMP_LAST = 4'hF;
  localparam logic [3:0] BITS_SHIFT = 4'h8;
  localparam logic [3:0] BITS_UART8 = 4'hA;
  localparam logic [3:0] BITS_UART9 = 4'hB;
  localparam logic [3:0] IDX_NINTH  = 4'h9;

endpackage : serial_port_pkg

/* serial_tx_buffer.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock; the drain side may hold off for any time.
*/
`timescale 1ns/1ps
module serial_tx_buffer #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk,        // CPU clock
  input  wire logic             arst_n,     // Async reset, low
  input  wire logic             in_valid,   // Word offered
  output logic                  in_ready,   // Room for a word
  input  wire logic [WIDTH-1:0] in_data,    // Word in
  output logic                  out_valid,  // Word waiting
  input  wire logic             out_ready,  // Drain takes word
  output logic      [WIDTH-1:0] out_data    // Oldest word
);

  logic [WIDTH-1:0] mem_ff [2];
  logic             wr_ptr_ff;
  logic             rd_ptr_ff;
  logic [1:0]       count_ff;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_ff != 2'd2);
  assign out_valid = (count_ff != 2'd0);
  assign out_data  = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'd0;
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= in_data;
        wr_ptr_ff         <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : serial_tx_buffer

/* serial_baud_gen.sv */
/*
  Bit-rate ticks: fixed divide-by-six shift ticks and the
  sixteen-times oversample tick for the UART modes.
  Assumes timer1_ovf is a one-cycle pulse per Timer 1 overflow.
*/
`timescale 1ns/1ps
module serial_baud_gen (
  input  wire logic       clk,         // CPU clock
  input  wire logic       arst_n,      // Async reset, low
  input  wire logic [1:0] mode,        // Operating mode
  input  wire logic       baud_double, // Rate doubling
  input  wire logic       timer1_ovf,  // Timer 1 overflow pulse
  output logic            shift_tick,  // Start of shift bit
  output logic            shift_half,  // Middle of shift bit
  output logic            smp_tick     // Oversample tick
);

  logic [2:0] div6_ff;
  logic       pre_ff;
  wire        fixed_rate = (mode == serial_port_pkg::MODE_UART9F);
  wire        src_pulse  = fixed_rate ? 1'b1 : timer1_ovf;

  // Shift mode: one bit each six clocks, no timer involved
  assign shift_tick = (div6_ff == 3'(serial_port_pkg::SHIFT_DIV - 1));
  assign shift_half = (div6_ff == 3'(serial_port_pkg::SHIFT_HALF - 1));

  // Fixed rate: clk/2 or clk/1 oversample = clk/32 or clk/16 bits
  // Variable rate: overflow/2 or overflow oversample
  assign smp_tick = src_pulse && (baud_double || pre_ff);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div6_ff <= 3'd0;
      pre_ff  <= 1'b0;
    end else begin
      div6_ff <= shift_tick ? 3'd0 : div6_ff + 3'd1;
      if (src_pulse) begin
        pre_ff <= ~pre_ff;
      end
    end
  end

endmodule : serial_baud_gen

/* serial_port.sv */
/*
  Serial port control, status and framing in four modes, reached on the
  special-function bus, with the serial buffer and power control bits.
  Assumes pins synchronous to clk and a Timer 1 overflow pulse input.
*/
`timescale 1ns/1ps

// Overview of operation
// - Bit 7 shows error flag or mode bit
// - Missing stop bit raises framing error flag
// - Framing error sticks until software clears it
// - Two mode bits select one of four modes
// - Shift mode clocks at CPU clock/6
// - Fixed 9-bit mode: clock/32, or /16 doubled
// - Doubling bit is zero after reset
// - Variable modes use Timer 1 overflow rate
// - Timer 1 any mode; its interrupt kept off
// - Receive enable permits or blocks reception
// - Ninth bit sent; ninth bit received captured
// - 8-bit mode captures stop bit as ninth
// - 9-bit qualified frames need ninth bit one
// - Transmit flag at end or stop start
// - Receive flag at end or mid stop bit
// - Load only if flag clear and qualified
// - Buffer write sends; read returns receive data
// - Reception start conditions per mode
module serial_port (
  input  wire logic       clk,          // CPU clock, 10 MHz
  input  wire logic       arst_n,       // Async reset, low
  input  wire logic [7:0] sfr_addr,     // Register address
  input  wire logic [7:0] sfr_wdata,    // Write data
  input  wire logic       sfr_wr,       // Write strobe
  input  wire logic       sfr_rd,       // Read strobe
  output logic      [7:0] sfr_rdata,    // Read data, next cycle
  output logic            tx_buf_ready, // Transmit buffer has room
  input  wire logic       timer1_ovf,   // Timer 1 overflow pulse
  input  wire logic       rxd_in,       // Receive pin level
  output logic            rxd_out,      // Shift-mode data out
  output logic            rxd_oe,       // Shift-mode data drive
  output logic            txd           // Transmit or shift clock
);

  // ==========================================================
  // Types and state
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01,
    TX_UART  = 2'b10
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_SHIFT = 2'b01,
    RX_UART  = 2'b10
  } rx_state_t;

  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  logic        mode_hi_ff, mode_lo_ff, mpq_ff, ren_ff, tx9_ff, rx9_ff;
  logic        txdone_ff, rxdone_ff, fe_ff;
  logic        baud_double_ff, frame_view_ff;
  logic [7:0]  rx_buf_ff;
  tx_state_t   tx_state_ff;
  rx_state_t   rx_state_ff;
  logic [10:0] tx_frame_ff;
  logic [3:0]  tx_cnt_ff, tx_div_ff;
  logic [3:0]  rx_cnt_ff, rx_div_ff;
  logic [7:0]  rx_shift_ff;
  logic [1:0]  rx_smp_ff;
  logic        rx_nin_ff, rxd_prev_ff, sclk_ff, txd_ff;
  logic [7:0]  nxt_rdata;
  localparam logic [3:0] REG_HI = serial_port_pkg::REG_RESET[7:4];
  localparam logic [3:0] REG_LO = serial_port_pkg::REG_RESET[3:0];

  // ==========================================================
  // Decode
  wire  [1:0] mode    = {mode_hi_ff, mode_lo_ff};
  wire        m_shift = (mode == serial_port_pkg::MODE_SHIFT);
  wire        m_uart8 = (mode == serial_port_pkg::MODE_UART8);
  wire        wr_ctrl = sfr_wr && (sfr_addr == serial_port_pkg::SERIAL_CTRL_ADDR);
  wire        wr_buf  = sfr_wr && (sfr_addr == serial_port_pkg::SERIAL_BUF_ADDR);
  wire        wr_pwr  = sfr_wr && (sfr_addr == serial_port_pkg::POWER_CTRL_ADDR);
  wire        shift_tick, shift_half, smp_tick;
  wire        buf_valid;
  wire  [8:0] buf_data;
  wire        bit7_view = frame_view_ff ? fe_ff : mode_hi_ff;
  wire  [7:0] ctrl_view = {bit7_view, mode_lo_ff, mpq_ff, ren_ff,
                           tx9_ff, rx9_ff, txdone_ff, rxdone_ff};
  wire  [7:0] pwr_view  = {baud_double_ff, frame_view_ff, 6'b00_0000};

  // ==========================================================
  // Rate ticks and transmit buffer
  serial_baud_gen u_baud (
    .clk         (clk),
    .arst_n      (arst_n),
    .mode        (mode),
    .baud_double (baud_double_ff),
    .timer1_ovf  (timer1_ovf),
    .shift_tick  (shift_tick),
    .shift_half  (shift_half),
    .smp_tick    (smp_tick)
  );

  // Buffer write queues a byte with the current ninth bit
  wire tx_take = (tx_state_ff == TX_IDLE) && buf_valid &&
                 (!m_shift || (shift_tick && rx_state_ff == RX_IDLE));

  serial_tx_buffer #(.WIDTH(9)) u_txbuf (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (wr_buf),
    .in_ready  (tx_buf_ready),
    .in_data   ({tx9_ff, sfr_wdata}),
    .out_valid (buf_valid),
    .out_ready (tx_take),
    .out_data  (buf_data)
  );

  // ==========================================================
  // Transmit
  wire [3:0] tx_bits = m_uart8 ? serial_port_pkg::BITS_UART8
                               : serial_port_pkg::BITS_UART9;
  wire tx_roll  = smp_tick && (tx_div_ff == serial_port_pkg::SMP_LAST);
  wire tx_sh_end = (tx_state_ff == TX_SHIFT) && shift_tick &&
                   (tx_cnt_ff == serial_port_pkg::BITS_SHIFT - 4'd1);
  wire tx_stop_go = (tx_state_ff == TX_UART) && tx_roll &&
                    (tx_cnt_ff == tx_bits - 4'd2);
  wire tx_set   = tx_sh_end || tx_stop_go;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_ff <= TX_IDLE;
      tx_frame_ff <= 11'h7FF;
      tx_cnt_ff   <= 4'd0;
      tx_div_ff   <= 4'd0;
    end else begin
      unique case (tx_state_ff)
        TX_IDLE: begin
          tx_cnt_ff <= 4'd0;
          tx_div_ff <= 4'd0;
          if (tx_take) begin
            tx_state_ff <= m_shift ? TX_SHIFT : TX_UART;
            // Ninth slot holds the stop bit in 8-bit mode
            tx_frame_ff <= m_shift ? {3'b111, buf_data[7:0]}
                         : {1'b1, (m_uart8 | buf_data[8]),
                            buf_data[7:0], 1'b0};
          end
        end
        TX_SHIFT: begin
          if (shift_tick) begin
            tx_frame_ff <= {1'b1, tx_frame_ff[10:1]};
            tx_cnt_ff   <= tx_cnt_ff + 4'd1;
            if (tx_sh_end) begin
              tx_state_ff <= TX_IDLE;
            end
          end
        end
        TX_UART: begin
          if (smp_tick) begin
            tx_div_ff <= tx_div_ff + 4'd1;
          end
          if (tx_roll) begin
            tx_frame_ff <= {1'b1, tx_frame_ff[10:1]};
            tx_cnt_ff   <= tx_cnt_ff + 4'd1;
            if (tx_cnt_ff == tx_bits - 4'd1) begin
              tx_state_ff <= TX_IDLE;
            end
          end
        end
        default: tx_state_ff <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Receive
  wire rx_fall  = rxd_prev_ff && !rxd_in;
  wire rx_sh_go = m_shift && ren_ff && !rxdone_ff &&
                  (tx_state_ff == TX_IDLE) && !buf_valid && shift_tick;
  wire rx_ua_go = !m_shift && ren_ff && rx_fall;
  wire rx_dec   = (rx_state_ff == RX_UART) && smp_tick &&
                  (rx_div_ff == serial_port_pkg::SMP_C);
  wire rx_bit   = maj3(rx_smp_ff[1], rx_smp_ff[0], rxd_in);
  wire rx_last  = m_uart8 ? (rx_cnt_ff == serial_port_pkg::IDX_NINTH)
                          : (rx_cnt_ff == serial_port_pkg::BITS_UART9 - 4'd1);
  wire rx_stop  = rx_dec && rx_last;
  wire rx_nin_v = m_uart8 ? rx_bit : rx_nin_ff;
  // Qualified load: flag clear and, if qualifying, ninth bit one
  wire rx_ok    = !rxdone_ff && (!mpq_ff || rx_nin_v);
  wire rx_sh_end = (rx_state_ff == RX_SHIFT) && shift_tick &&
                   (rx_cnt_ff == serial_port_pkg::BITS_SHIFT);
  wire rx_set   = rx_sh_end || (rx_stop && rx_ok);
  wire fe_set   = rx_stop && !rx_bit;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_ff <= RX_IDLE;
      rx_cnt_ff   <= 4'd0;
      rx_div_ff   <= 4'd0;
      rx_shift_ff <= 8'h00;
      rx_smp_ff   <= 2'b11;
      rx_nin_ff   <= 1'b0;
      rxd_prev_ff <= 1'b1;
    end else begin
      rxd_prev_ff <= rxd_in;
      unique case (rx_state_ff)
        RX_IDLE: begin
          rx_cnt_ff <= 4'd0;
          rx_div_ff <= 4'd0;
          if (rx_sh_go) begin
            rx_state_ff <= RX_SHIFT;
          end else if (rx_ua_go) begin
            rx_state_ff <= RX_UART;
          end
        end
        RX_SHIFT: begin
          if (shift_half) begin
            rx_shift_ff <= {rxd_in, rx_shift_ff[7:1]};
            rx_cnt_ff   <= rx_cnt_ff + 4'd1;
          end
          if (rx_sh_end) begin
            rx_state_ff <= RX_IDLE;
          end
        end
        RX_UART: begin
          if (smp_tick) begin
            rx_div_ff <= rx_div_ff + 4'd1;
            if (rx_div_ff == serial_port_pkg::SMP_A) begin
              rx_smp_ff[1] <= rxd_in;
            end
            if (rx_div_ff == serial_port_pkg::SMP_B) begin
              rx_smp_ff[0] <= rxd_in;
            end
            if (rx_div_ff == serial_port_pkg::SMP_LAST) begin
              rx_cnt_ff <= rx_cnt_ff + 4'd1;
            end
          end
          if (rx_dec) begin
            if (rx_cnt_ff == 4'd0 && rx_bit) begin
              rx_state_ff <= RX_IDLE;
            end else if (rx_last) begin
              rx_state_ff <= RX_IDLE;
            end else if (rx_cnt_ff == serial_port_pkg::IDX_NINTH) begin
              rx_nin_ff <= rx_bit;
            end else if (rx_cnt_ff != 4'd0) begin
              rx_shift_ff <= {rx_bit, rx_shift_ff[7:1]};
            end
          end
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pins
  wire sh_busy = (tx_state_ff == TX_SHIFT) || (rx_state_ff == RX_SHIFT);
  wire sh_fall = shift_tick && ((tx_take && m_shift) || rx_sh_go ||
                 (sh_busy && !tx_sh_end && !rx_sh_end));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_ff <= 1'b1;
      txd_ff  <= 1'b1;
    end else begin
      if (sh_fall) begin
        sclk_ff <= 1'b0;
      end else if (shift_half || !sh_busy) begin
        sclk_ff <= 1'b1;
      end
      txd_ff <= (tx_state_ff == TX_UART) ? tx_frame_ff[0] : 1'b1;
    end
  end

  assign txd     = m_shift ? sclk_ff : txd_ff;
  assign rxd_out = tx_frame_ff[0];
  assign rxd_oe  = (tx_state_ff == TX_SHIFT);

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {mode_hi_ff, mode_lo_ff, mpq_ff, ren_ff} <= REG_HI;
      {tx9_ff, rx9_ff, txdone_ff, rxdone_ff}   <= REG_LO;
      fe_ff          <= 1'b0;
      baud_double_ff <= 1'b0;
      frame_view_ff  <= 1'b0;
      rx_buf_ff      <= serial_port_pkg::REG_RESET;
      sfr_rdata      <= serial_port_pkg::REG_RESET;
    end else begin
      if (wr_ctrl) begin
        if (!frame_view_ff) begin
          mode_hi_ff <= sfr_wdata[serial_port_pkg::B_MODE_HI];
        end
        mode_lo_ff <= sfr_wdata[serial_port_pkg::B_MODE_LO];
        mpq_ff     <= sfr_wdata[serial_port_pkg::B_MPQ];
        ren_ff     <= sfr_wdata[serial_port_pkg::B_REN];
        tx9_ff     <= sfr_wdata[serial_port_pkg::B_TX9];
      end
      if (wr_pwr) begin
        baud_double_ff <= sfr_wdata[serial_port_pkg::B_BAUD_DOUBLE];
        frame_view_ff  <= sfr_wdata[serial_port_pkg::B_FRAME_VIEW];
      end
      // Hardware set wins over a same-cycle software write
      fe_ff <= fe_set ||
               ((wr_ctrl && frame_view_ff) ?
                sfr_wdata[serial_port_pkg::B_MODE_HI] : fe_ff);
      txdone_ff <= tx_set || (wr_ctrl ?
                   sfr_wdata[serial_port_pkg::B_TXDONE] : txdone_ff);
      rxdone_ff <= rx_set || (wr_ctrl ?
                   sfr_wdata[serial_port_pkg::B_RXDONE] : rxdone_ff);
      if (rx_set) begin
        rx_buf_ff <= rx_shift_ff;
      end
      if (rx_stop && rx_ok) begin
        rx9_ff <= rx_nin_v;
      end else if (wr_ctrl) begin
        rx9_ff <= sfr_wdata[serial_port_pkg::B_RX9];
      end
      if (sfr_rd) begin
        sfr_rdata <= nxt_rdata;
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    unique case (sfr_addr)
      serial_port_pkg::SERIAL_CTRL_ADDR: nxt_rdata = ctrl_view;
      serial_port_pkg::SERIAL_BUF_ADDR:  nxt_rdata = rx_buf_ff;
      serial_port_pkg::POWER_CTRL_ADDR:  nxt_rdata = pwr_view;
      default:                           nxt_rdata = 8'h00;
    endcase
  end

endmodule : serial_port

/* serial_port_chk.sv */
/*
  Port checker for the serial port, bound onto serial_port.
  Assumes one clock domain and software-only power control bits.
*/
`timescale 1ns/1ps
module serial_port_chk (
  input wire logic       clk,          // CPU clock
  input wire logic       arst_n,       // Async reset, low
  input wire logic [7:0] sfr_addr,     // Register address
  input wire logic [7:0] sfr_wdata,    // Write data
  input wire logic       sfr_wr,       // Write strobe
  input wire logic       sfr_rd,       // Read strobe
  input wire logic [7:0] sfr_rdata,    // Read data
  input wire logic       tx_buf_ready, // Buffer room
  input wire logic       rxd_oe,       // Data pin drive
  input wire logic       txd           // Serial out
);
  // ==========================================================
  // Mirrors of software-written bits
  logic [7:0] pwr_ff;
  logic [6:3] ctl_ff;
  logic       hi_ff;
  wire        wr_c = sfr_wr && sfr_addr == serial_port_pkg::SERIAL_CTRL_ADDR;
  wire        wr_p = sfr_wr && sfr_addr == serial_port_pkg::POWER_CTRL_ADDR;
  wire        rd_c = sfr_rd && sfr_addr == serial_port_pkg::SERIAL_CTRL_ADDR;
  wire        rd_p = sfr_rd && sfr_addr == serial_port_pkg::POWER_CTRL_ADDR;
  wire        rd_u = sfr_rd && !rd_c && !rd_p
                     && sfr_addr != serial_port_pkg::SERIAL_BUF_ADDR;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_ff <= 8'h00;
      ctl_ff <= 4'h0;
      hi_ff  <= 1'b0;
    end else begin
      if (wr_p) pwr_ff <= sfr_wdata & 8'hC0;
      if (wr_c) ctl_ff <= sfr_wdata[6:3];
      if (wr_c && !pwr_ff[6]) hi_ff <= sfr_wdata[7];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Assertions
  a_reset_idle: assert property ($rose(arst_n) |-> txd && !rxd_oe
    && sfr_rdata == 8'h00) else $error("bad idle after reset");
  a_unmapped_zero: assert property (rd_u |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
  a_power_bits: assert property (rd_p |=> sfr_rdata == pwr_ff)
    else $error("power control readback wrong");
  a_ctrl_bits: assert property (rd_c |=> sfr_rdata[6:3] == ctl_ff)
    else $error("control readback wrong");
  a_mode_view: assert property (rd_c && !pwr_ff[6] |=>
    sfr_rdata[7] == hi_ff) else $error("bit 7 mode view wrong");
  a_buf_fill: assert property ($fell(tx_buf_ready) |->
    $past(sfr_wr && sfr_addr == serial_port_pkg::SERIAL_BUF_ADDR))
    else $error("buffer filled without write");
  a_oe_shift: assert property (rxd_oe |-> !hi_ff && !ctl_ff[6])
    else $error("data pin driven outside shift mode");

  c_shift_drive: cover property (rxd_oe);
  c_buf_full: cover property ($fell(tx_buf_ready));
  c_error_view: cover property (rd_c && pwr_ff[6]);
endmodule : serial_port_chk

bind serial_port serial_port_chk u_serial_port_chk (.clk, .arst_n,
  .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .tx_buf_ready,
  .rxd_oe, .txd);

/* remote_uart.sv */
/*
  Remote serial transceiver on the line: sends and captures frames.
  Assumes bit periods given in CPU clock cycles; line idles high.
*/
`timescale 1ns/1ps
module remote_uart (
  input  wire logic clk, // CPU clock
  input  wire logic txd, // Line from device
  output logic      rxd  // Line to device
);
  initial rxd = 1'b1;

  // Start, data LSB first, optional ninth, then stop level st
  task automatic send(input logic [7:0] d, input logic b8, st,
                      input int nb, per);
    logic [10:0] f;
    f = (nb == 9) ? {st, b8, d, 1'b0} : {1'b1, st, d, 1'b0};
    for (int i = 0; i < nb + 2; i++) begin
      rxd = f[i];
      repeat (per) @(posedge clk);
      #1;
    end
    rxd = 1'b1;
    repeat (per) @(posedge clk);
    #1;
  endtask : send

  // Returns stop in bit 9, ninth in bit 8, data below
  task automatic recv(input int nb, per, output logic [9:0] v);
    v = '0;
    @(negedge txd);
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (per) @(posedge clk);
      v[(i == nb) ? 9 : i] = txd;
    end
    #1;
  endtask : recv
endmodule : remote_uart

/* tb_serial_port.sv */
/*
  Testbench of the serial port: register sequences and line frames.
  Assumes the remote model and a Timer 1 overflow every second cycle.
*/
`timescale 1ns/1ps
module tb_serial_port;
  localparam logic [7:0] CTL = serial_port_pkg::SERIAL_CTRL_ADDR;
  localparam logic [7:0] BUF = serial_port_pkg::SERIAL_BUF_ADDR;
  localparam logic [7:0] PWR = serial_port_pkg::POWER_CTRL_ADDR;
  logic       clk, arst_n, sfr_wr, sfr_rd, timer1_ovf, rem_rxd;
  logic       tx_buf_ready, rxd_in, rxd_out, rxd_oe, txd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  logic [9:0] fr;
  int         bad_count, checks;
  realtime    t0;

  assign rxd_in = rxd_oe ? rxd_out : rem_rxd;
  serial_port u_serial_port (.clk, .arst_n, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rd, .sfr_rdata, .tx_buf_ready, .timer1_ovf, .rxd_in, .rxd_out,
    .rxd_oe, .txd);
  remote_uart u_remote_uart (.clk, .txd, .rxd(rem_rxd));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) timer1_ovf <= #1 ~timer1_ovf;

  // ==========================================================
  // Access tasks
  task automatic wr(input logic [7:0] a, d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk) #1;
    sfr_wr = 1'b0;
    @(posedge clk) #1;
  endtask : wr

  task automatic chk(input logic [9:0] got, exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk) #1;
    sfr_rd = 1'b0;
    @(posedge clk) #1;
    chk({2'b00, sfr_rdata}, {2'b00, e});
  endtask : rdc

  task automatic summarize;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // ==========================================================
  // Tests
  initial begin
    {sfr_wr, sfr_rd, timer1_ovf, arst_n} = 4'h0;
    {sfr_addr, sfr_wdata, bad_count, checks} = '0;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    @(posedge clk) #1;
    rdc(CTL, 8'h00);
    rdc(PWR, 8'h00);
    rdc(8'h55, 8'h00);
    // Fixed 9-bit mode, slow rate, ninth bit one
    wr(CTL, 8'h88);
    wr(BUF, 8'hA5);
    u_remote_uart.recv(9, 32, fr);
    chk(fr, 10'h3A5);
    rdc(CTL, 8'h8A);
    // Doubled rate with the buffer filled to refusal
    wr(PWR, 8'h80);
    rdc(PWR, 8'h80);
    wr(CTL, 8'h80);
    fork
      begin
        wr(BUF, 8'h01);
        wr(BUF, 8'h02);
        wr(BUF, 8'h03);
        chk({9'h000, tx_buf_ready}, 10'h000);
        wr(BUF, 8'h04);
      end
      for (int i = 1; i < 4; i++) begin
        u_remote_uart.recv(9, 16, fr);
        chk(fr, 10'h200 + 10'(i));
      end
    join
    // Reception in fixed 9-bit mode
    wr(PWR, 8'h00);
    wr(CTL, 8'h90);
    u_remote_uart.send(8'h3C, 1'b1, 1'b1, 9, 32);
    rdc(CTL, 8'h95);
    rdc(BUF, 8'h3C);
    wr(CTL, 8'hB0);
    u_remote_uart.send(8'h77, 1'b0, 1'b1, 9, 32);
    rdc(CTL, 8'hB0);
    u_remote_uart.send(8'h66, 1'b1, 1'b1, 9, 32);
    rdc(CTL, 8'hB5);
    rdc(BUF, 8'h66);
    wr(CTL, 8'h80);
    u_remote_uart.send(8'h12, 1'b1, 1'b1, 9, 32);
    rdc(CTL, 8'h80);
    // Framing error: raise, stick, clear through bit 7
    wr(CTL, 8'h90);
    u_remote_uart.send(8'h44, 1'b1, 1'b0, 9, 32);
    wr(PWR, 8'h40);
    rdc(CTL, 8'h95);
    wr(PWR, 8'h00);
    wr(CTL, 8'h90);
    u_remote_uart.send(8'h45, 1'b1, 1'b1, 9, 32);
    wr(PWR, 8'h40);
    rdc(CTL, 8'h95);
    wr(CTL, 8'h10);
    rdc(CTL, 8'h10);
    wr(PWR, 8'h00);
    rdc(CTL, 8'h90);
    // 8-bit mode on the overflow rate, doubled
    wr(PWR, 8'h80);
    wr(CTL, 8'h50);
    u_remote_uart.send(8'h5A, 1'b0, 1'b1, 8, 32);
    rdc(CTL, 8'h55);
    u_remote_uart.send(8'h11, 1'b0, 1'b1, 8, 32);
    rdc(BUF, 8'h5A);
    wr(BUF, 8'hC3);
    u_remote_uart.recv(8, 32, fr);
    chk(fr, 10'h2C3);
    // 9-bit mode on the overflow rate, doubled
    wr(CTL, 8'hC8);
    wr(BUF, 8'h3E);
    u_remote_uart.recv(9, 32, fr);
    chk(fr, 10'h33E);
    // Shift mode transmit
    wr(PWR, 8'h00);
    wr(CTL, 8'h00);
    wr(BUF, 8'h96);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      if (i == 0) t0 = $realtime;
      if (i == 1) chk(10'(int'($realtime - t0)), 10'd600);
      v[i] = rxd_out;
    end
    repeat (6) @(posedge clk);
    #1;
    chk({2'b00, v}, 10'h096);
    rdc(CTL, 8'h02);
    // Shift mode receive of the idle line
    wr(CTL, 8'h10);
    repeat (60) @(posedge clk);
    #1;
    rdc(CTL, 8'h11);
    rdc(BUF, 8'hFF);
    summarize();
  end
endmodule : tb_serial_port
